// ---- rdc_pkg.sv ----
// rdc_pkg: constants and types for the reset default configuration block
// Functional notes
// - power-on, warm and max reset all restore PLL and clock defaults
// - after reset every PLL is disabled and placed in bypass
// - bypassed PLLs leave the reference clock (typ. 24 MHz) driving the chip
// - PLL control register resets to the bypassed, disabled encoding
// - oscillator strap 0 selects mode 1, strap 1 selects mode 2
// - only a subset of module power slots is enabled after reset
// - boot code 011 enables serial port 0 in slot 19
// - slots 27, 29, 30, 31, 34, 35 and 41 are enabled at the latch for every boot code; later writes can clear all but slot 34
// - DMA slots 0 and 1 enabled only for codes 000, 001, 100, 110
// - async memory interface slot 14 enabled only for codes 000, 001
// - each boot peripheral slot is enabled for its own boot code
// - every slot not named for the code comes out of reset disabled
// - straps are latched at reset, then pins return to normal function
package rdc_pkg;
  localparam int SLOT_N  = 52;
  localparam int ADDR_W  = 12;
  localparam int EN_HI_W = SLOT_N - 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PLL    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_EN_LO  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_EN_HI  = 12'h00c;

  // field positions
  localparam int PLL_EN_BIT  = 0;
  localparam int PLL_BYP_BIT = 1;
  localparam int ST_BSEL_LSB = 0;
  localparam int ST_OSC_BIT  = 3;
  localparam int ST_DONE_BIT = 4;
  localparam int ST_REF_BIT  = 5;

  // reset values
  localparam logic              PLL_EN_RST  = 1'b0;
  localparam logic              PLL_BYP_RST = 1'b1;
  localparam logic [SLOT_N-1:0] EN_RST      = 52'h0;

  // consecutive agreeing strap samples needed before latching
  localparam logic [3:0] SETTLE_CYCLES = 4'h4;

  // module power slot numbers
  localparam int SLOT_DMA_CC    = 0;
  localparam int SLOT_DMA_TC0   = 1;
  localparam int SLOT_USB       = 9;
  localparam int SLOT_ASYNC_MEM = 14;
  localparam int SLOT_CARD0     = 15;
  localparam int SLOT_SERIAL0   = 19;
  localparam int SLOT_HOST_PORT = 21;
  localparam int SLOT_SPERIPH0  = 22;
  localparam int SLOT_TIMER0    = 27;
  localparam int SLOT_TIMER2    = 29;
  localparam int SLOT_SYSTEM    = 30;
  localparam int SLOT_CPU       = 31;
  localparam int SLOT_R34       = 34;
  localparam int SLOT_EMU       = 35;
  localparam int SLOT_ETHERNET  = 40;
  localparam int SLOT_RTC       = 41;
  // slots 16, 32, 33, 36, 37, 48, 49
  localparam logic [SLOT_N-1:0] RESERVED_MASK = 52'h3_0033_0001_0000;

  // boot select codes
  localparam logic [2:0] BOOT_NAND    = 3'h0;
  localparam logic [2:0] BOOT_ASYNC   = 3'h1;
  localparam logic [2:0] BOOT_CARD    = 3'h2;
  localparam logic [2:0] BOOT_SERIAL  = 3'h3;
  localparam logic [2:0] BOOT_USB     = 3'h4;
  localparam logic [2:0] BOOT_SPERIPH = 3'h5;
  localparam logic [2:0] BOOT_ETH     = 3'h6;
  localparam logic [2:0] BOOT_HOST    = 3'h7;

  typedef enum logic [1:0] {PH_SETTLE, PH_RUN} phase_t;

  typedef struct packed {
    logic [2:0] boot_select_strap;
    logic       oscillator_config_strap;
  } straps_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
endpackage

// ---- strap_sync.sv ----
// strap_sync: three-stage synchroniser for the configuration straps
`timescale 1ns/10ps
module strap_sync (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire rdc_pkg::straps_t pins,
  output wire rdc_pkg::straps_t value,
  output wire logic             agree
);
  typedef struct packed {
    rdc_pkg::straps_t s1;
    rdc_pkg::straps_t s2;
    rdc_pkg::straps_t s3;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // s1 is only read by s2
  assign value = st_q.s3;
  assign agree = (st_q.s2 == st_q.s3);
endmodule

// ---- reset_defaults.sv ----
// reset_defaults: strap latch, PLL defaults and module slot enables
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module reset_defaults (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire rdc_pkg::apb_req_t  apb_req,
  output wire rdc_pkg::apb_rsp_t  apb_rsp,
  input  wire rdc_pkg::straps_t   strap_pins,
  output wire logic               strap_released,
  output wire logic               pll_enable,
  output wire logic               pll_bypass,
  output wire logic               use_reference_clock,
  output wire logic               osc_mode_2,
  output wire logic [51:0]        module_enable
);
  localparam int N = rdc_pkg::SLOT_N;

  typedef struct packed {
    rdc_pkg::phase_t   phase;
    logic [3:0]        settle;
    rdc_pkg::straps_t  lat;
    logic              released;
    logic              pll_en;
    logic              pll_byp;
    logic              ref_sel;
    logic              osc2;
    logic [N-1:0]      en;
    rdc_pkg::apb_rsp_t rsp;
  } state_t;

  state_t           st_q;
  state_t           st_d;
  rdc_pkg::straps_t sync_val;
  logic             sync_agree;

  strap_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (strap_pins),
    .value   (sync_val),
    .agree   (sync_agree)
  );

  // reserved slots forced off, slot 34 forced on
  function automatic logic [N-1:0] legal_slots(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = v & ~rdc_pkg::RESERVED_MASK;
    r[rdc_pkg::SLOT_R34] = 1'b1;
    return r;
  endfunction

  function automatic logic [N-1:0] default_enables(input logic [2:0] code);
    logic [N-1:0] v;
    v = '0;
    v[rdc_pkg::SLOT_TIMER0] = 1'b1;
    v[rdc_pkg::SLOT_TIMER2] = 1'b1;
    v[rdc_pkg::SLOT_SYSTEM] = 1'b1;
    v[rdc_pkg::SLOT_CPU]    = 1'b1;
    v[rdc_pkg::SLOT_R34]    = 1'b1;
    v[rdc_pkg::SLOT_EMU]    = 1'b1;
    v[rdc_pkg::SLOT_RTC]    = 1'b1;
    case (code)
      rdc_pkg::BOOT_NAND, rdc_pkg::BOOT_ASYNC: begin
        v[rdc_pkg::SLOT_DMA_CC]    = 1'b1;
        v[rdc_pkg::SLOT_DMA_TC0]   = 1'b1;
        v[rdc_pkg::SLOT_ASYNC_MEM] = 1'b1;
      end
      rdc_pkg::BOOT_CARD: begin
        v[rdc_pkg::SLOT_CARD0] = 1'b1;
      end
      rdc_pkg::BOOT_SERIAL: begin
        v[rdc_pkg::SLOT_SERIAL0] = 1'b1;
      end
      rdc_pkg::BOOT_USB: begin
        v[rdc_pkg::SLOT_DMA_CC]  = 1'b1;
        v[rdc_pkg::SLOT_DMA_TC0] = 1'b1;
        v[rdc_pkg::SLOT_USB]     = 1'b1;
      end
      rdc_pkg::BOOT_SPERIPH: begin
        v[rdc_pkg::SLOT_SPERIPH0] = 1'b1;
      end
      rdc_pkg::BOOT_ETH: begin
        v[rdc_pkg::SLOT_DMA_CC]   = 1'b1;
        v[rdc_pkg::SLOT_DMA_TC0]  = 1'b1;
        v[rdc_pkg::SLOT_ETHERNET] = 1'b1;
      end
      default: begin
        v[rdc_pkg::SLOT_HOST_PORT] = 1'b1;
      end
    endcase
    return v;
  endfunction

  logic              acc_first;
  logic              acc_commit;
  logic [31:0]       rd_word;
  logic              rd_bad;
  logic [N-1:0]      wr_vec;

  always_comb begin
    st_d       = st_q;
    acc_first  = apb_req.psel && apb_req.penable && !st_q.rsp.pready;
    acc_commit = apb_req.psel && apb_req.penable && st_q.rsp.pready;
    rd_word    = '0;
    rd_bad     = 1'b0;
    wr_vec     = st_q.en;

    // strap sampling after reset release
    case (st_q.phase)
      rdc_pkg::PH_SETTLE: begin
        if (!sync_agree) begin
          st_d.settle = '0;
        end else if (st_q.settle == rdc_pkg::SETTLE_CYCLES - 4'h1) begin
          st_d.lat      = sync_val;
          st_d.released = 1'b1;
          st_d.osc2     = sync_val.oscillator_config_strap;
          st_d.en       = legal_slots(
                            default_enables(
                              sync_val.boot_select_strap));
          st_d.phase    = rdc_pkg::PH_RUN;
        end else begin
          st_d.settle = st_q.settle + 4'h1;
        end
      end
      rdc_pkg::PH_RUN: begin
        st_d.phase = rdc_pkg::PH_RUN;
      end
      default: begin
        st_d.phase = rdc_pkg::PH_SETTLE;
      end
    endcase

    // register read decode
    case (apb_req.paddr)
      rdc_pkg::OFS_STATUS: begin
        rd_word[rdc_pkg::ST_BSEL_LSB +: 3] = st_q.lat.boot_select_strap;
        rd_word[rdc_pkg::ST_OSC_BIT]  = st_q.osc2;
        rd_word[rdc_pkg::ST_DONE_BIT] = st_q.released;
        rd_word[rdc_pkg::ST_REF_BIT]  = st_q.ref_sel;
      end
      rdc_pkg::OFS_PLL: begin
        rd_word[rdc_pkg::PLL_EN_BIT]  = st_q.pll_en;
        rd_word[rdc_pkg::PLL_BYP_BIT] = st_q.pll_byp;
      end
      rdc_pkg::OFS_EN_LO: begin
        rd_word = st_q.en[31:0];
      end
      rdc_pkg::OFS_EN_HI: begin
        rd_word[rdc_pkg::EN_HI_W-1:0] = st_q.en[N-1:32];
      end
      default: begin
        rd_bad = 1'b1;
      end
    endcase

    // answer one cycle into the access phase
    st_d.rsp.pready  = acc_first;
    st_d.rsp.pslverr = acc_first && rd_bad;
    st_d.rsp.prdata  = (acc_first && !apb_req.pwrite) ? rd_word : '0;

    // writes land on the edge where pready is sampled high
    if (acc_commit && apb_req.pwrite && !st_q.rsp.pslverr) begin
      case (apb_req.paddr)
        rdc_pkg::OFS_PLL: begin
          st_d.pll_en  = apb_req.pwdata[rdc_pkg::PLL_EN_BIT];
          st_d.pll_byp = apb_req.pwdata[rdc_pkg::PLL_BYP_BIT];
        end
        rdc_pkg::OFS_EN_LO: begin
          wr_vec[31:0] = apb_req.pwdata;
          if (st_q.released) begin
            st_d.en = legal_slots(wr_vec);
          end
        end
        rdc_pkg::OFS_EN_HI: begin
          wr_vec[N-1:32] = apb_req.pwdata[rdc_pkg::EN_HI_W-1:0];
          if (st_q.released) begin
            st_d.en = legal_slots(wr_vec);
          end
        end
        default: begin
          st_d.pll_en = st_d.pll_en;
        end
      endcase
    end

    // raw reference clock whenever no PLL output is in use
    st_d.ref_sel = st_d.pll_byp || !st_d.pll_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.phase    <= rdc_pkg::PH_SETTLE;
      st_q.pll_en   <= rdc_pkg::PLL_EN_RST;
      st_q.pll_byp  <= rdc_pkg::PLL_BYP_RST;
      st_q.ref_sel  <= 1'b1;
      st_q.en       <= rdc_pkg::EN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp             = st_q.rsp;
  assign strap_released      = st_q.released;
  assign pll_enable          = st_q.pll_en;
  assign pll_bypass          = st_q.pll_byp;
  assign use_reference_clock = st_q.ref_sel;
  assign osc_mode_2          = st_q.osc2;
  assign module_enable       = st_q.en;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] lat_code;
  logic       code_dma;
  logic       code_async;
  int         exp_ones;
  assign lat_code   = st_q.lat.boot_select_strap;
  assign code_dma   = lat_code inside {3'h0, 3'h1, 3'h4, 3'h6};
  assign code_async = lat_code inside {3'h0, 3'h1};
  assign exp_ones   = 7 + (code_dma ? 2 : 0) + (code_async ? 1 : 0)
                      + ((lat_code >= 3'h2) ? 1 : 0);

  sequence s_latch;
    $rose(strap_released);
  endsequence

  // enable register write completing at this edge
  logic en_wr;
  assign en_wr = apb_req.psel && apb_req.penable && apb_rsp.pready
                 && apb_req.pwrite
                 && (apb_req.paddr == rdc_pkg::OFS_EN_LO
                     || apb_req.paddr == rdc_pkg::OFS_EN_HI);

  sequence s_pll_read;
    apb_req.psel && apb_req.penable && !apb_rsp.pready
      && !apb_req.pwrite && apb_req.paddr == rdc_pkg::OFS_PLL;
  endsequence

  property p_reset_exit;
    !$past(presetn) |-> pll_bypass && !pll_enable && !strap_released;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("defaults not present after reset release");

  property p_pll_default;
    !strap_released |-> pll_bypass && !pll_enable;
  endproperty
  a_pll_default: assert property (p_pll_default)
    else $error("PLL not bypassed and disabled before latch");

  property p_ref_clock;
    use_reference_clock == (pll_bypass || !pll_enable);
  endproperty
  a_ref_clock: assert property (p_ref_clock)
    else $error("reference clock select inconsistent with PLL state");

  property p_pll_reg;
    s_pll_read and (pll_bypass && !pll_enable) |=>
      apb_rsp.prdata[1:0] == 2'h2;
  endproperty
  a_pll_reg: assert property (p_pll_reg)
    else $error("PLL register read does not show bypassed default");

  property p_osc_mode;
    s_latch |-> osc_mode_2 == $past(sync_val.oscillator_config_strap);
  endproperty
  a_osc_mode: assert property (p_osc_mode)
    else $error("oscillator mode does not follow strap");

  property p_slot_count;
    s_latch |-> $countones(module_enable) == exp_ones;
  endproperty
  a_slot_count: assert property (p_slot_count)
    else $error("wrong number of slots enabled at latch");

  property p_serial_boot;
    s_latch and (lat_code == 3'h3) |-> module_enable[19];
  endproperty
  a_serial_boot: assert property (p_serial_boot)
    else $error("serial port 0 not enabled for serial boot");

  property p_always_on;
    s_latch |-> module_enable[27] && module_enable[29]
      && module_enable[30] && module_enable[31] && module_enable[34]
      && module_enable[35] && module_enable[41];
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on slot missing at latch");

  property p_dma_slots;
    s_latch |-> module_enable[0] == code_dma
      && module_enable[1] == code_dma;
  endproperty
  a_dma_slots: assert property (p_dma_slots)
    else $error("DMA slot enables wrong for boot code");

  property p_async_slot;
    s_latch |-> module_enable[14] == code_async;
  endproperty
  a_async_slot: assert property (p_async_slot)
    else $error("async memory slot enable wrong for boot code");

  property p_settle;
    s_latch |-> $past(sync_agree, 1) && $past(sync_agree, 2)
      && $past(sync_agree, 3) && $past(sync_agree, 4);
  endproperty
  a_settle: assert property (p_settle)
    else $error("straps latched before they settled");

  property p_release_hold;
    strap_released |=> strap_released;
  endproperty
  a_release_hold: assert property (p_release_hold)
    else $error("strap pins reclaimed after release");

  property p_hold;
    strap_released && !en_wr |=> $stable(module_enable);
  endproperty
  a_hold: assert property (p_hold)
    else $error("module enables changed without a write");

  property p_reserved;
    (module_enable & rdc_pkg::RESERVED_MASK) == '0
      && (!strap_released || module_enable[34]);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved slot enable wrong");

  property p_apb_answer;
    apb_req.psel && apb_req.penable && !apb_rsp.pready |=>
      apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not a single cycle after access start");
endmodule

// ---- tb.sv ----
// tb: self-checking bench for the reset default configuration block
`timescale 1ns/10ps
module tb;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  rdc_pkg::apb_req_t req = '0;
  rdc_pkg::apb_rsp_t rsp;
  rdc_pkg::straps_t  strap = '0;
  logic              released;
  logic              pll_en;
  logic              pll_byp;
  logic              use_ref;
  logic              osc2;
  logic [51:0]       en;
  logic [51:0]       m_en;
  logic [31:0]       seed = 32'h09669321;
  logic [31:0]       rd;
  logic              err;
  logic              o;
  logic [1:0]        k;
  int                rsv[7] = '{16, 32, 33, 36, 37, 48, 49};
  int                err_total = 0;
  int                compares = 0;

  always #5 pclk = ~pclk;

  reset_defaults i_dut (
    .pclk                (pclk),
    .presetn             (presetn),
    .apb_req             (req),
    .apb_rsp             (rsp),
    .strap_pins          (strap),
    .strap_released      (released),
    .pll_enable          (pll_en),
    .pll_bypass          (pll_byp),
    .use_reference_clock (use_ref),
    .osc_mode_2          (osc2),
    .module_enable       (en)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // default slot enables per boot code
  function automatic logic [51:0] dflt(input int c);
    logic [51:0] v;
    int          q[$];
    v = '0;
    q = {27, 29, 30, 31, 34, 35, 41};
    case (c)
      0, 1: q = {q, 0, 1, 14};
      2: q.push_back(15);
      3: q.push_back(19);
      4: q = {q, 0, 1, 9};
      5: q.push_back(22);
      6: q = {q, 0, 1, 40};
      default: q.push_back(21);
    endcase
    foreach (q[i]) v[q[i]] = 1'b1;
    return v;
  endfunction

  task automatic chk(input logic [51:0] seen, input logic [51:0] exp,
                     input string m);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b1, 1'b0, "apb no pready");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read data");
    chk(err, 1'b0, "read error");
  endtask

  initial begin
    #200000;
    err_total++;
    summarize;
  end

  initial begin
    for (int c = 0; c < 8; c++) begin
      @(posedge pclk);
      seed = lfsr(seed);
      o = seed[0];
      presetn <= 1'b0;
      strap   <= {3'(c), o};
      repeat (12) @(posedge pclk);
      #1;
      chk(pll_en, 1'b0, "pll enable in reset");
      chk(pll_byp, 1'b1, "pll bypass in reset");
      chk(use_ref, 1'b1, "ref clock in reset");
      chk(en, '0, "enables in reset");
      chk(released, 1'b0, "released in reset");
      // all-zero straps may latch four edges after release, so the
      // write is set up at the release edge and must still be dropped
      fork
        @(posedge pclk) presetn <= 1'b1;
        apb(1'b1, rdc_pkg::OFS_EN_LO, 32'hffffffff);
      join
      chk(en, '0, "enables before latch");
      chk(released, 1'b0, "early release");
      for (int n = 0; n < 20 && released !== 1'b1; n++) begin
        @(posedge pclk);
        #1;
      end
      chk(released, 1'b1, "strap latch");
      m_en = dflt(c);
      chk(en, m_en, "default enables");
      chk(osc2, o, "oscillator mode");
      chk(pll_en, 1'b0, "pll enable default");
      chk(pll_byp, 1'b1, "pll bypass default");
      chk(use_ref, 1'b1, "ref clock default");
      rdc(rdc_pkg::OFS_STATUS, {26'h0, 2'b11, o, 3'(c)});
      rdc(rdc_pkg::OFS_PLL, 32'h2);
      rdc(rdc_pkg::OFS_EN_LO, m_en[31:0]);
      rdc(rdc_pkg::OFS_EN_HI, {12'h0, m_en[51:32]});
      // pll codes end with enable on, bypass off, so next reset matters
      for (int i = 0; i < 4; i++) begin
        k = 2'(i ^ 2);
        apb(1'b1, rdc_pkg::OFS_PLL, {30'h0, k});
        chk(pll_en, k[0], "pll enable write");
        chk(pll_byp, k[1], "pll bypass write");
        chk(use_ref, k[1] || !k[0], "ref clock select");
        rdc(rdc_pkg::OFS_PLL, {30'h0, k});
      end
      seed = lfsr(seed);
      apb(1'b1, rdc_pkg::OFS_EN_LO, seed);
      m_en[31:0] = seed;
      seed = lfsr(seed);
      apb(1'b1, rdc_pkg::OFS_EN_HI, seed);
      m_en[51:32] = seed[19:0];
      foreach (rsv[j]) m_en[rsv[j]] = 1'b0;
      m_en[34] = 1'b1;
      chk(en, m_en, "enables after write");
      rdc(rdc_pkg::OFS_EN_HI, {12'h0, m_en[51:32]});
      apb(1'b1, 12'h010, seed);
      chk(err, 1'b1, "unmapped write error");
      chk(en, m_en, "unmapped write effect");
      apb(1'b0, 12'hffc, 32'h0);
      chk(err, 1'b1, "unmapped read error");
      chk(rd, '0, "unmapped read data");
      apb(1'b1, rdc_pkg::OFS_STATUS, seed);
      chk(err, 1'b0, "status write error");
      rdc(rdc_pkg::OFS_STATUS, {26'h0, 2'b01, o, 3'(c)});
      // straps moving after the latch must change nothing
      @(posedge pclk);
      strap <= ~strap;
      repeat (10) @(posedge pclk);
      #1;
      chk(en, m_en, "enables after strap move");
      chk(osc2, o, "osc after strap move");
      chk(released, 1'b1, "release sticky");
    end
    summarize;
  end
endmodule
